// ===== rtl/eew_eeprom_target.sv
// two-wire serial eeprom target: framing, selection, page write, reads
// assumes an open-drain data wire resolved outside; scl comes from the master
module eew_eeprom_target #(
  parameter int         WriteCycles = eew_pkg::WRITE_CYCLES,
  // device-type code: value is arbitrary
  parameter logic [3:0] DevTypeCode = 4'h5
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       sclPin,
  input  wire logic       sdaIn,
  output wire logic       sdaOut,
  output wire logic       sdaOe,
  input  wire logic [2:0] strappedSelectPins,
  input  wire logic       writeProtect,
  output wire logic       writeBusy
);
  import eew_pkg::*;

  // ****************************************
  // pin conditioning and bus events
  // ****************************************
  eew_pins_t rawPins;
  eew_pins_t cleanPins;
  logic      sclPrev_r;
  logic      sdaPrev_r;

  assign rawPins = {sclPin, sdaIn, writeProtect, strappedSelectPins};

  eew_pin_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .rawPins  (rawPins),
    .cleanPins(cleanPins)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclPrev_r <= 1'h1;
      sdaPrev_r <= 1'h1;
    end else begin
      sclPrev_r <= cleanPins.scl;
      sdaPrev_r <= cleanPins.sda;
    end
  end

  wire sclRise   = cleanPins.scl & ~sclPrev_r;
  wire sclFall   = ~cleanPins.scl & sclPrev_r;
  wire sclHigh   = cleanPins.scl & sclPrev_r;
  wire startSeen = sclHigh & sdaPrev_r & ~cleanPins.sda; // RULE3
  wire stopSeen  = sclHigh & ~sdaPrev_r & cleanPins.sda; // RULE4

  // ****************************************
  // state
  // ****************************************
  eew_state_t        state_r;
  eew_state_t        state_nxt;
  eew_kind_t         kind_r;
  eew_kind_t         kind_nxt;
  logic [3:0]        bitCnt_r;
  logic [3:0]        bitCnt_nxt;
  logic [7:0]        shift_r;
  logic [7:0]        shift_nxt;
  logic              readOp_r;
  logic              readOp_nxt;
  logic              wpNack_r;
  logic              wpNack_nxt;
  logic              gotData_r;
  logic              gotData_nxt;
  logic              ackOk_r;
  logic              ackOk_nxt;
  logic              sdaOe_r;
  logic              sdaOe_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [6:0]        progIdx_r;
  logic [6:0]        progIdx_nxt;
  logic [WAIT_W-1:0] waitCnt_r;
  logic [WAIT_W-1:0] waitCnt_nxt;
  logic              bufWr;
  logic              bufClr;

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] mem [MEM_WORDS];
  logic [7:0] bufData;
  logic       bufValid;

  wire [ADDR_W-1:0] addrInc  = addr_r + 14'h1;
  wire [7:0]        rdByte   = mem[addr_r];
  wire [7:0]        nextByte = mem[addrInc];
  wire              byteDone = sclFall & (bitCnt_r == BITS_PER_WORD);
  // select pins are pulled low at the pad, so floating straps compare as zero
  wire              selMatch = (shift_r[7:4] == DevTypeCode)
                               & (shift_r[3:1] == cleanPins.sel); // RULE11 RULE15
  wire              progLive = (progIdx_r < 7'(PAGE_BYTES));
  wire              commitEn = (state_r == ST_PROG) & progLive & bufValid;
  wire              progEnd  = (waitCnt_r == WAIT_W'(WriteCycles - 1));

  eew_page_buf u_buf (
    .core_clk(core_clk),
    .sys_rst (sys_rst),
    .clr     (bufClr),
    .wrEn    (bufWr),
    .wrIdx   (addr_r[PAGE_W-1:0]),
    .wrData  (shift_r),
    .rdIdx   (progIdx_r[PAGE_W-1:0]),
    .rdData  (bufData),
    .rdValid (bufValid)
  );

  // valid buffered bytes land one per clock over the first 64 cycles of the timed cycle
  always_ff @(posedge core_clk) begin
    if (commitEn) begin
      mem[{addr_r[ADDR_W-1:PAGE_W], progIdx_r[PAGE_W-1:0]}] <= bufData; // RULE18
    end
  end

  // ****************************************
  // protocol sequencing
  // ****************************************
  always_comb begin
    state_nxt   = state_r;
    kind_nxt    = kind_r;
    bitCnt_nxt  = bitCnt_r;
    shift_nxt   = shift_r;
    readOp_nxt  = readOp_r;
    wpNack_nxt  = wpNack_r;
    gotData_nxt = gotData_r;
    ackOk_nxt   = ackOk_r;
    sdaOe_nxt   = sdaOe_r;
    addr_nxt    = addr_r;
    progIdx_nxt = progIdx_r;
    waitCnt_nxt = waitCnt_r;
    bufWr       = 1'h0;
    bufClr      = 1'h0;
    if (state_r == ST_PROG) begin
      // pins are not looked at here, so polls go unanswered
      sdaOe_nxt   = 1'h0; // RULE17 RULE22
      waitCnt_nxt = waitCnt_r + 20'h1;
      if (progLive) begin
        progIdx_nxt = progIdx_r + 7'h1;
      end
      if (progEnd) begin
        state_nxt = ST_IDLE; // RULE6
      end
    end else if (startSeen) begin
      state_nxt  = ST_RXB; // RULE3
      kind_nxt   = KIND_SEL;
      bitCnt_nxt = 4'h0;
      sdaOe_nxt  = 1'h0;
      wpNack_nxt = 1'h0;
      // a start after data bytes abandons that write
      gotData_nxt = 1'h0;
    end else if (stopSeen) begin
      sdaOe_nxt = 1'h0;
      if (gotData_r) begin
        state_nxt   = ST_PROG; // RULE5
        gotData_nxt = 1'h0;
        progIdx_nxt = 7'h0;
        waitCnt_nxt = '0;
      end else begin
        state_nxt = ST_IDLE; // RULE4 RULE9
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          sdaOe_nxt = 1'h0;
        end
        ST_RXB: begin
          if (sclRise && bitCnt_r < BITS_PER_WORD) begin
            shift_nxt  = {shift_r[6:0], cleanPins.sda}; // RULE1 RULE23
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          if (byteDone) begin
            state_nxt = ST_ACKO;
            sdaOe_nxt = 1'h1; // RULE7
            case (kind_r)
              KIND_SEL: begin
                if (selMatch) begin
                  readOp_nxt = shift_r[0]; // RULE12 RULE14
                end else begin
                  state_nxt = ST_IDLE; // RULE13
                  sdaOe_nxt = 1'h0;
                end
              end
              KIND_AHI: begin
                addr_nxt = {shift_r[5:0], addr_r[7:0]}; // RULE16 RULE23
              end
              KIND_ALO: begin
                addr_nxt = {addr_r[ADDR_W-1:8], shift_r}; // RULE16
              end
              default: begin
                if (cleanPins.wp) begin
                  wpNack_nxt = 1'h1; // RULE20 RULE21
                  sdaOe_nxt  = 1'h0;
                end else begin
                  bufWr       = 1'h1;
                  addr_nxt    = pageNext(addr_r); // RULE18 RULE19
                  gotData_nxt = 1'h1;
                end
              end
            endcase
          end
        end
        ST_ACKO: begin
          if (sclFall) begin
            sdaOe_nxt  = 1'h0;
            bitCnt_nxt = 4'h0;
            if (wpNack_r) begin
              state_nxt = ST_IDLE; // RULE20
            end else if (kind_r == KIND_SEL && readOp_r) begin
              state_nxt  = ST_TXB; // RULE21
              shift_nxt  = rdByte;
              sdaOe_nxt  = ~rdByte[7]; // RULE1 RULE23
              bitCnt_nxt = 4'h1;
            end else begin
              state_nxt = ST_RXB;
              case (kind_r)
                KIND_SEL: begin
                  kind_nxt    = KIND_AHI;
                  bufClr      = 1'h1;
                  gotData_nxt = 1'h0;
                end
                KIND_AHI: kind_nxt = KIND_ALO;
                default:  kind_nxt = KIND_DATA;
              endcase
            end
          end
        end
        ST_TXB: begin
          if (byteDone) begin
            sdaOe_nxt = 1'h0; // RULE8
            ackOk_nxt = 1'h0;
            state_nxt = ST_ACKI;
          end else if (sclFall) begin
            shift_nxt  = {shift_r[6:0], 1'h0};
            sdaOe_nxt  = ~shift_r[6]; // RULE1
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
        end
        ST_ACKI: begin
          if (sclRise) begin
            ackOk_nxt = ~cleanPins.sda;
          end
          if (sclFall) begin
            if (ackOk_r) begin
              state_nxt  = ST_TXB; // RULE8
              addr_nxt   = addrInc;
              shift_nxt  = nextByte;
              sdaOe_nxt  = ~nextByte[7];
              bitCnt_nxt = 4'h1;
            end else begin
              // stay quiet until a start or stop
              state_nxt = ST_IDLE; // RULE10
              sdaOe_nxt = 1'h0;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          sdaOe_nxt = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      kind_r    <= KIND_SEL;
      bitCnt_r  <= 4'h0;
      shift_r   <= 8'h00;
      readOp_r  <= 1'h0;
      wpNack_r  <= 1'h0;
      gotData_r <= 1'h0;
      ackOk_r   <= 1'h0;
      sdaOe_r   <= 1'h0;
      addr_r    <= '0;
      progIdx_r <= 7'h0;
      waitCnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      kind_r    <= kind_nxt;
      bitCnt_r  <= bitCnt_nxt;
      shift_r   <= shift_nxt;
      readOp_r  <= readOp_nxt;
      wpNack_r  <= wpNack_nxt;
      gotData_r <= gotData_nxt;
      ackOk_r   <= ackOk_nxt;
      sdaOe_r   <= sdaOe_nxt;
      addr_r    <= addr_nxt;
      progIdx_r <= progIdx_nxt;
      waitCnt_r <= waitCnt_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // open drain: only ever pulls low
  assign sdaOut    = 1'h0;
  assign sdaOe     = sdaOe_r;
  assign writeBusy = (state_r == ST_PROG);

endmodule

// ===== rtl/eew_pkg.sv
// shared constants, types and states of the two-wire eeprom target
// assumes a 100 MHz core clock and bus pins sampled from outside its domain
//
// Notes on behaviour
// RULE1: sample data on clock rise, change driven data after clock fall.
// RULE2: master changes data only while clock is low, except start/stop.
// RULE3: data falling while clock high is a start; device detects it.
// RULE4: data rising while clock high is a stop; after read, go standby.
// RULE5: stop after write data ends intake and begins the self-timed write.
// RULE6: self-timed write lasts at most 5 ms from the stop.
// RULE7: words are 8 bits; receiver pulls data low on ninth clock.
// RULE8: after a read byte, release; master ack low gets next address byte.
// RULE9: read with no ack then stop ends read, returns to standby.
// RULE10: no ack and no stop after read byte: stay released, send nothing.
// RULE11: selection word is type code, select bits 2,1,0, direction bit.
// RULE12: direction low starts a write, high starts a read.
// RULE13: wrong type code or select bits: standby without acknowledge.
// RULE14: matching selection word is acknowledged, then operation proceeds.
// RULE15: unconnected select pins read as low.
// RULE16: write sends two address bytes, each acknowledged, then data.
// RULE17: bus activity is ignored while the self-timed write runs.
// RULE18: up to 64 bytes per write, only six low address bits increment.
// RULE19: low address bits wrap inside the page; later bytes overwrite.
// RULE20: protect high: ack selection and address, nack first data, no program.
// RULE21: protect covers whole array; reads work regardless of protect.
// RULE22: polling selection with direction low nacks while busy, acks after.
// RULE23: bytes go msb first; first address byte holds upper bits.
package eew_pkg;

  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int ADDR_W        = 14;
  localparam int MEM_WORDS     = 16384;
  localparam int PAGE_W        = 6;
  localparam int PAGE_BYTES    = 64;
  localparam int CLK_HZ        = 100_000_000;
  localparam int WRITE_TIME_MS = 5;
  // longest time, so rounded down
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / 1000);
  localparam int WAIT_W        = 20;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;

  // ****************************************
  // pin bundle
  // ****************************************
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] sel;
  } eew_pins_t;

  // idle bus floats high
  localparam eew_pins_t PINS_RESET = '{scl: 1'h1, sda: 1'h1, wp: 1'h0, sel: 3'h0};

  // ****************************************
  // protocol states
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RXB   = 6'h02,
    ST_ACKO  = 6'h04,
    ST_TXB   = 6'h08,
    ST_ACKI  = 6'h10,
    ST_PROG  = 6'h20
  } eew_state_t;

  typedef enum logic [1:0] {
    KIND_SEL  = 2'h0,
    KIND_AHI  = 2'h1,
    KIND_ALO  = 2'h2,
    KIND_DATA = 2'h3
  } eew_kind_t;

  // next address inside the same page
  function automatic logic [ADDR_W-1:0] pageNext(input logic [ADDR_W-1:0] a);
    pageNext = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 6'h1};
  endfunction

endpackage

// ===== rtl/eew_pin_sync.sv
// three-stage synchroniser for the bus pins and straps
// assumes pins are asynchronous to core_clk; output moves once stages 2 and 3 agree
module eew_pin_sync (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire eew_pkg::eew_pins_t rawPins,
  output wire eew_pkg::eew_pins_t cleanPins
);
  import eew_pkg::*;

  eew_pins_t stage1_r;
  eew_pins_t stage2_r;
  eew_pins_t stage3_r;
  eew_pins_t clean_r;
  eew_pins_t clean_nxt;

  // agreement of stages 2 and 3 also swallows single-sample glitches
  assign clean_nxt = (stage2_r & stage3_r) | (clean_r & (stage2_r | stage3_r));
  assign cleanPins = clean_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1_r <= PINS_RESET;
      stage2_r <= PINS_RESET;
      stage3_r <= PINS_RESET;
      clean_r  <= PINS_RESET;
    end else begin
      stage1_r <= rawPins;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      clean_r  <= clean_nxt;
    end
  end

endmodule

// ===== rtl/eew_page_buf.sv
// one page of pending write data with a valid bit per byte
// assumes the owner clears it before each write and drains it during programming
module eew_page_buf (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clr,
  input  wire logic       wrEn,
  input  wire logic [5:0] wrIdx,
  input  wire logic [7:0] wrData,
  input  wire logic [5:0] rdIdx,
  output wire logic [7:0] rdData,
  output wire logic       rdValid
);
  import eew_pkg::*;

  logic [7:0]            bytes_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid_r;

  assign rdData  = bytes_r[rdIdx];
  assign rdValid = valid_r[rdIdx];

  // a repeated index simply overwrites the earlier byte
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      bytes_r[wrIdx] <= wrData; // RULE19
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || clr) begin
      valid_r <= '0;
    end else if (wrEn) begin
      valid_r[wrIdx] <= 1'h1;
    end
  end

endmodule

// ===== tb/eew_target_checker.sv
// concurrent checks on the eeprom target's ports
// assumes it is bound to the target and sees only its ports
module eew_target_checker #(
  parameter int WriteCycles = 2000
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       sclPin,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [2:0] strappedSelectPins,
  input wire logic       writeProtect,
  input wire logic       writeBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // busy length counter
  // ****
  int busyCnt_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !writeBusy) busyCnt_r <= 0;
    else busyCnt_r <= busyCnt_r + 1;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ****
  // assertions
  // ****
  out_low_a: assert property (sdaOut == 1'h0)
    else $error("data output not held low");
  // answers move only after the seen clock fall
  oe_change_a: assert property ($changed(sdaOe) |-> !sclPin && !$past(sclPin, 4))
    else $error("data enable moved outside clock low");
  busy_quiet_a: assert property (writeBusy |-> !sdaOe)
    else $error("data driven during write cycle");
  busy_rise_a: assert property ($rose(writeBusy) |-> sclPin && sdaIn ##1 writeBusy[*8])
    else $error("write cycle not started by a stop");
  busy_max_a: assert property (writeBusy |-> busyCnt_r < WriteCycles)
    else $error("write cycle too long");
  busy_full_a: assert property ($fell(writeBusy) |-> busyCnt_r == WriteCycles)
    else $error("write cycle length wrong");
  stop_idle_a: assert property (sclPin && $past(sclPin) && $rose(sdaIn) |=> !sdaOe[*8])
    else $error("data driven after stop");
  start_idle_a: assert property (sclPin && $past(sclPin) && $fell(sdaIn) |=> !sdaOe[*8])
    else $error("data driven after start");
  reset_idle_a: assert property ($fell(sys_rst) |-> !sdaOe && !writeBusy)
    else $error("outputs active after reset");
  cover property ($rose(writeBusy));
  cover property (writeProtect && $rose(sdaOe));
  cover property (writeBusy && sclPin && $fell(sdaIn));
endmodule

// ===== tb/eew_bm.sv
// two-wire bus master model driving the target's clock and data
// assumes the bench resolves the open-drain data wire with a pull-up
module eew_bm #(
  parameter int Half = 40
) (
  input  wire logic core_clk,
  input  wire logic sdaWire,
  output logic      sclDrv_r,
  output logic      sdaLow_r
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // bus primitives
  // ****
  // clock stands high outside frames
  initial begin
    sclDrv_r = 1'h1;
    sdaLow_r = 1'h0;
  end
  task automatic pause(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic xfer(input logic b, output logic r);
    sdaLow_r = !b;
    pause(Half / 2);
    sclDrv_r = 1'h1;
    pause(Half);
    r = sdaWire;
    sclDrv_r = 1'h0;
    pause(Half / 2);
  endtask
  task automatic start();
    sdaLow_r = 1'h0;
    pause(Half / 2);
    sclDrv_r = 1'h1;
    pause(Half);
    sdaLow_r = 1'h1;
    pause(Half);
    sclDrv_r = 1'h0;
    pause(Half / 2);
  endtask
  task automatic stop();
    sdaLow_r = 1'h1;
    pause(Half / 2);
    sclDrv_r = 1'h1;
    pause(Half);
    sdaLow_r = 1'h0;
    pause(Half);
  endtask
  // ninth clock released so the target can answer
  task automatic sendByte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'h1, nack);
  endtask
  task automatic recvByte(input logic nackBit, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'h1, d[i]);
    xfer(nackBit, r);
  endtask
endmodule

// ===== tb/eew_eeprom_target_tb_top.sv
// self-checking bench for the two-wire eeprom target
// assumes the master model and checker are compiled before it
module eew_eeprom_target_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import eew_pkg::*;
  // ****
  // clock, reset, wires
  // ****
  // short write cycle keeps the run brief
  localparam int WC = 2000;
  // device-type code: value is arbitrary
  localparam logic [3:0] DEV = 4'h5;
  logic       core_clk = 1'h0;
  logic       sys_rst = 1'h1;
  logic       writeProtect = 1'h0;
  logic [2:0] straps = 3'h0;
  logic       sclPin, sdaLow, sdaOut, sdaOe, writeBusy, n;
  logic [7:0] d;
  int         failures = 0;
  int         checksDone = 0;
  wire        sdaWire = !(sdaLow || (sdaOe && !sdaOut));
  always #5 core_clk = !core_clk;
  eew_eeprom_target #(.WriteCycles(WC), .DevTypeCode(DEV)) eew_eeprom_target_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .sclPin(sclPin), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .strappedSelectPins(straps),
    .writeProtect(writeProtect), .writeBusy(writeBusy));
  eew_bm #(.Half(40)) eew_bm_i (
    .core_clk(core_clk), .sdaWire(sdaWire), .sclDrv_r(sclPin), .sdaLow_r(sdaLow));
  // ****
  // helpers
  // ****
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ackIs(input string what, input logic exp);
    check(what, {7'h0, n}, {7'h0, exp});
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic selAddr(input logic [13:0] a);
    eew_bm_i.start();
    eew_bm_i.sendByte({DEV, straps, 1'h0}, n);
    ackIs("sel", 1'h0);
    eew_bm_i.sendByte({2'h0, a[13:8]}, n);
    ackIs("ahi", 1'h0);
    eew_bm_i.sendByte(a[7:0], n);
    ackIs("alo", 1'h0);
  endtask
  task automatic readAt(input logic [13:0] a, input logic [7:0] e0, input logic [7:0] e1);
    selAddr(a);
    eew_bm_i.start();
    eew_bm_i.sendByte({DEV, straps, 1'h1}, n);
    ackIs("rsel", 1'h0);
    eew_bm_i.recvByte(1'h0, d);
    check("rd0", d, e0);
    eew_bm_i.recvByte(1'h1, d);
    check("rd1", d, e1);
    eew_bm_i.stop();
  endtask
  task automatic poll(input logic exp);
    eew_bm_i.start();
    eew_bm_i.sendByte({DEV, straps, 1'h0}, n);
    ackIs("poll", exp);
    eew_bm_i.stop();
  endtask
  // ****
  // scenarios
  // ****
  // starts two bytes before the page end so the low bits wrap
  task automatic t_page();
    logic [7:0] pat [4] = '{8'ha5, 8'h5a, 8'hc3, 8'h3c};
    int k = 0;
    selAddr(14'h12fe);
    foreach (pat[i]) begin
      eew_bm_i.sendByte(pat[i], n);
      ackIs("data", 1'h0);
    end
    eew_bm_i.stop();
    check("busy", {7'h0, writeBusy}, 8'h1);
    poll(1'h1);
    while (writeBusy === 1'h1 && k < WC) begin
      @(posedge core_clk);
      k++;
    end
    #1;
    check("busyend", {7'h0, writeBusy}, 8'h0);
    if (writeBusy !== 1'h0) complete_run();
    poll(1'h0);
    readAt(14'h12fe, 8'ha5, 8'h5a);
    readAt(14'h12c0, 8'hc3, 8'h3c);
    $display("page write test done");
  endtask
  task automatic t_protect();
    writeProtect = 1'h1;
    selAddr(14'h12fe);
    eew_bm_i.sendByte(8'h00, n);
    ackIs("wpdata", 1'h1);
    eew_bm_i.stop();
    check("wpbusy", {7'h0, writeBusy}, 8'h0);
    readAt(14'h12fe, 8'ha5, 8'h5a);
    writeProtect = 1'h0;
    $display("protect test done");
  endtask
  task automatic t_select();
    logic [7:0] w;
    straps = 3'h5;
    for (int j = 0; j < 9; j++) begin
      w = (j < 8) ? {DEV, 3'(j), 1'h0} : {4'h6, 3'h5, 1'h0};
      eew_bm_i.start();
      eew_bm_i.sendByte(w, n);
      ackIs("match", j != 5);
      eew_bm_i.stop();
    end
    straps = 3'h0;
    $display("select test done");
  endtask
  // no ack and no stop: the target must keep the line released
  task automatic t_idle();
    selAddr(14'h12ff);
    eew_bm_i.start();
    eew_bm_i.sendByte({DEV, straps, 1'h1}, n);
    eew_bm_i.recvByte(1'h1, d);
    check("last", d, 8'h5a);
    eew_bm_i.recvByte(1'h1, d);
    check("released", d, 8'hff);
    eew_bm_i.stop();
    $display("release test done");
  endtask
  // data byte, then a start straight into a read: the stop must not program
  task automatic t_abort();
    selAddr(14'h12c0);
    eew_bm_i.sendByte(8'h00, n);
    ackIs("abdata", 1'h0);
    eew_bm_i.start();
    eew_bm_i.sendByte({DEV, straps, 1'h1}, n);
    ackIs("absel", 1'h0);
    eew_bm_i.recvByte(1'h1, d);
    check("abread", d, 8'h3c);
    eew_bm_i.stop();
    check("abbusy", {7'h0, writeBusy}, 8'h0);
    $display("abort test done");
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    sys_rst = 1'h0;
    repeat (5) @(posedge core_clk);
    #1;
    t_page();
    t_protect();
    t_select();
    t_idle();
    t_abort();
    complete_run();
  end
endmodule

bind eew_eeprom_target eew_target_checker #(.WriteCycles(WriteCycles)) eew_target_checker_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .strappedSelectPins(strappedSelectPins), .writeProtect(writeProtect),
  .writeBusy(writeBusy));
